/* logic/aux_counter.sv */
`timescale 1ns/1ps
`include "fetch_params.svh"

module aux_counter (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic load_i,
	input wire logic [15:0] load_data_i,
	input wire logic inc_i,
	input wire logic dec_i,
	output logic [15:0] value_o
);
	localparam int CB = `AUX_COUNT_BITS;

	logic [15:0] value_r, value_nxt;

	// Only the low field counts; upper bits never see a carry or borrow
	always_comb begin
		value_nxt = value_r;
		if (load_i) begin
			value_nxt = load_data_i;
		end else if (inc_i) begin
			value_nxt = {value_r[15:CB], value_r[CB-1:0] + 9'h001};
		end else if (dec_i) begin
			value_nxt = {value_r[15:CB], value_r[CB-1:0] - 9'h001};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_r <= `AUX_RESET;
		end else if (ce_i) begin
			value_r <= value_nxt;
		end
	end

	assign value_o = value_r;

endmodule

/* logic/fetch_params.svh */
`ifndef FETCH_PARAMS_SVH
`define FETCH_PARAMS_SVH

// Program counter
`define PC_RESET 12'h000
`define PC_STEP 12'h001

// On-chip program store sizes (words)
`define ROM_WORDS_SMALL 13'h0600
`define ROM_WORDS_LARGE 13'h1000

// Last word user code may occupy; the rest is kept for factory test
`define USER_TOP_SMALL 12'h5F3
`define USER_TOP_LARGE 12'hF9F

// On-chip data RAM sizes (words)
`define RAM_WORDS_SMALL 9'h090
`define RAM_WORDS_LARGE 9'h100

// I/O ports that reach the system control register on serial variants
`define PORT_SYSCTL_LOW 3'h0
`define PORT_SYSCTL_HIGH 3'h1

// Reset values
`define SYSCTL_RESET 16'h0000
`define AUX_RESET 16'h0000
`define WORD_RESET 16'h0000
`define STACK_RESET 12'h000

// Address register counter field width
`define AUX_COUNT_BITS 9

`endif

/* logic/fetch_pkg.sv */
package fetch_pkg;

	// Operation presented by the decoder for the current instruction
	typedef enum logic [3:0] {
		OP_NEXT   = 4'h0,
		OP_BRANCH = 4'h1,
		OP_CALL   = 4'h2,
		OP_RET    = 4'h3,
		OP_INTR   = 4'h4,
		OP_IN     = 4'h5,
		OP_OUT    = 4'h6,
		OP_TABLE_READ   = 4'h7,
		OP_TABLE_WRITE   = 4'h8,
		OP_LDP    = 4'h9,
		OP_LARP   = 4'hA,
		OP_LAR    = 4'hB
	} op_t;

	// Post-instruction change of the active address register
	typedef enum logic [1:0] {
		AUX_KEEP = 2'h0,
		AUX_INC  = 2'h1,
		AUX_DEC  = 2'h2
	} aux_mod_t;

	// Bus cycle sequencer
	typedef enum logic [1:0] {
		ST_RUN  = 2'h0,
		ST_IO   = 2'h1,
		ST_TBL1 = 2'h2,
		ST_TBL2 = 2'h3
	} state_t;

endpackage

/* logic/fetch_unit.sv */
`timescale 1ns/1ps
`include "fetch_params.svh"
module fetch_unit #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter bit SERIAL_VARIANT = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic memory_mode_pin_i,
	input wire logic cmd_valid_i,
	input wire fetch_pkg::op_t cmd_op_i,
	input wire logic [11:0] cmd_target_i,
	input wire logic [15:0] cmd_data_i,
	input wire logic cmd_direct_i,
	input wire logic [6:0] cmd_offset_i,
	input wire logic cmd_aux_sel_i,
	input wire fetch_pkg::aux_mod_t cmd_aux_mod_i,
	output logic cmd_ready_o,
	input wire logic prog_we_i,
	input wire logic [11:0] prog_addr_i,
	input wire logic [15:0] prog_data_i,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe_o,
	output logic [11:0] addr_o,
	output logic memory_enable_strobe_n_o,
	output logic data_enable_strobe_n_o,
	output logic write_strobe_n_o,
	output logic [15:0] instr_o,
	output logic instr_valid_o,
	output logic [11:0] next_fetch_pointer_o,
	output logic data_page_bit_o,
	output logic address_reg_select_o,
	output logic [15:0] address_reg_zero_o,
	output logic [15:0] address_reg_one_o,
	output logic [31:0] system_control_o
);
	import fetch_pkg::*;

	localparam logic [12:0] ROM_LIMIT =
		LARGE_VARIANT ? `ROM_WORDS_LARGE : `ROM_WORDS_SMALL;
	localparam logic [8:0] RAM_LIMIT =
		LARGE_VARIANT ? `RAM_WORDS_LARGE : `RAM_WORDS_SMALL;
	localparam int ROM_N = int'(ROM_LIMIT);
	localparam int RAM_N = int'(RAM_LIMIT);

	// Program store and data RAM, sized by variant
	logic [15:0] rom_mem [0:ROM_N-1];
	logic [15:0] ram_mem [0:RAM_N-1];

	state_t state_r, state_nxt;
	op_t op_r, op_nxt;
	logic [11:0] pc_r, pc_nxt, tbl_r, tbl_nxt, push_val;
	logic [2:0] port_r, port_nxt;
	logic [7:0] dma_r, dma_nxt, dma_now;
	logic dp_r, dp_nxt, arp_r, arp_nxt, push, pop, accept;
	logic [15:0] dout_r, dout_nxt;
	logic [3:0][11:0] stack_r, stack_nxt;
	logic [1:0][15:0] aux_val;
	logic mode_s1_r, mode_s2_r, mc_mode, ext_pc;
	logic [15:0] data_s1_r, data_s2_r;
	logic p1_v_r, p1_ram_r, p1_int_r, p2_v_r, p2_ram_r, p2_int_r;
	logic p1_v_nxt, p1_ram_nxt, p1_int_nxt;
	logic [15:0] p1_word_r, p1_word_nxt, p2_word_r, word2;
	logic [7:0] p1_dma_r, p2_dma_r;
	logic [15:0] instr_r, instr_nxt, sc_lo_r, sc_lo_nxt, sc_hi_r, sc_hi_nxt;
	logic instr_v_r, instr_v_nxt;

	function automatic logic [15:0] rom_rd(input logic [11:0] a);
		rom_rd = ({1'b0, a} < ROM_LIMIT) ? rom_mem[a] : `WORD_RESET;
	endfunction

	function automatic logic [15:0] ram_rd(input logic [7:0] a);
		ram_rd = ({1'b0, a} < RAM_LIMIT) ? ram_mem[a] : `WORD_RESET;
	endfunction

	function automatic logic port_int(input logic [2:0] p);
		port_int = SERIAL_VARIANT &&
			(p == `PORT_SYSCTL_LOW || p == `PORT_SYSCTL_HIGH);
	endfunction

	// Mode pin is asynchronous; serial parts ignore it and fetch off chip only past the on-chip store
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_s1_r <= 1'b1;
			mode_s2_r <= 1'b1;
			data_s1_r <= `WORD_RESET;
			data_s2_r <= `WORD_RESET;
		end else if (ce_i) begin
			mode_s1_r <= memory_mode_pin_i;
			mode_s2_r <= mode_s1_r;
			data_s1_r <= data_i;
			data_s2_r <= data_s1_r;
		end
	end
	assign mc_mode = SERIAL_VARIANT ? 1'b1 : mode_s2_r;
	// Past the on-chip store the fetch goes off chip
	assign ext_pc = !mc_mode || ({1'b0, pc_r} >= ROM_LIMIT);

	assign accept = ce_i && cmd_valid_i && (state_r == ST_RUN);
	// Direct: page bit on top of seven offset bits; indirect: active reg
	assign dma_now = cmd_direct_i ? {dp_r, cmd_offset_i}
		: (arp_r ? aux_val[1][7:0] : aux_val[0][7:0]);

	// Sequencer and program counter; pointer moves once per accepted decode
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		pc_nxt = pc_r;
		tbl_nxt = tbl_r;
		port_nxt = port_r;
		dma_nxt = dma_r;
		dp_nxt = dp_r;
		arp_nxt = arp_r;
		dout_nxt = dout_r;
		push = 1'b0;
		pop = 1'b0;
		push_val = pc_r + `PC_STEP;
		case (state_r)
			ST_RUN: begin
				if (accept) begin
					pc_nxt = pc_r + `PC_STEP;
					op_nxt = cmd_op_i;
					dma_nxt = dma_now;
					case (cmd_op_i)
						OP_BRANCH: pc_nxt = cmd_target_i;
						OP_CALL: begin
							pc_nxt = cmd_target_i;
							push = 1'b1;
						end
						OP_INTR: begin
							pc_nxt = cmd_target_i;
							push = 1'b1;
							push_val = pc_r;
						end
						OP_RET: begin
							pc_nxt = stack_r[0];
							pop = 1'b1;
						end
						OP_IN: begin
							state_nxt = ST_IO;
							port_nxt = cmd_data_i[2:0];
						end
						OP_OUT: begin
							state_nxt = ST_IO;
							port_nxt = cmd_data_i[2:0];
							dout_nxt = ram_rd(dma_now);
						end
						OP_TABLE_READ: begin
							state_nxt = ST_TBL1;
							tbl_nxt = cmd_data_i[11:0];
						end
						OP_TABLE_WRITE: begin
							state_nxt = ST_TBL1;
							tbl_nxt = cmd_data_i[11:0];
							dout_nxt = ram_rd(dma_now);
						end
						OP_LDP: dp_nxt = cmd_data_i[0];
						OP_LARP: arp_nxt = cmd_data_i[0];
						default: ;
					endcase
				end
			end
			ST_IO: state_nxt = ST_RUN;
			ST_TBL1: state_nxt = ST_TBL2;
			ST_TBL2: state_nxt = ST_RUN;
			default: state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_RUN;
			op_r <= OP_NEXT;
			pc_r <= `PC_RESET;
			tbl_r <= `PC_RESET;
			port_r <= `PORT_SYSCTL_LOW;
			dma_r <= 8'h00;
			dp_r <= 1'b0;
			arp_r <= 1'b0;
			dout_r <= `WORD_RESET;
			stack_r <= {4{`STACK_RESET}};
		end else if (ce_i) begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			pc_r <= pc_nxt;
			tbl_r <= tbl_nxt;
			port_r <= port_nxt;
			dma_r <= dma_nxt;
			dp_r <= dp_nxt;
			arp_r <= arp_nxt;
			dout_r <= dout_nxt;
			stack_r <= stack_nxt;
		end
	end

	// Return stack: a fifth push drops the oldest, a pop repeats the bottom
	for (genvar g = 0; g < 4; g++) begin : g_stack
		localparam int UP = (g == 0) ? 0 : g - 1;
		localparam int DN = (g == 3) ? 3 : g + 1;
		assign stack_nxt[g] = push ? ((g == 0) ? push_val : stack_r[UP])
			: (pop ? stack_r[DN] : stack_r[g]);
	end

	// Address registers; the counter step lands after the instruction
	for (genvar g = 0; g < 2; g++) begin : g_aux
		aux_counter u_aux (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.ce_i(ce_i),
			.load_i(accept && cmd_op_i == OP_LAR && cmd_aux_sel_i == 1'(g)),
			.load_data_i(cmd_data_i),
			.inc_i(accept && !cmd_direct_i && cmd_aux_mod_i == AUX_INC
				&& arp_r == 1'(g)),
			.dec_i(accept && !cmd_direct_i && cmd_aux_mod_i == AUX_DEC
				&& arp_r == 1'(g)),
			.value_o(aux_val[g])
		);
	end

	// Read pipe: both sources take the same two stages as the bus
	// synchroniser, so external code runs at the internal rate
	always_comb begin
		p1_v_nxt = 1'b0;
		p1_ram_nxt = 1'b0;
		p1_int_nxt = 1'b1;
		p1_word_nxt = `WORD_RESET;
		if (state_r == ST_RUN) begin
			p1_v_nxt = 1'b1;
			p1_int_nxt = !ext_pc;
			p1_word_nxt = rom_rd(pc_r);
		end else if (state_r == ST_IO && op_r == OP_IN) begin
			p1_v_nxt = 1'b1;
			p1_ram_nxt = 1'b1;
			p1_int_nxt = port_int(port_r);
			p1_word_nxt = (port_r == `PORT_SYSCTL_HIGH) ? sc_hi_r : sc_lo_r;
		end else if (state_r == ST_TBL1 && op_r == OP_TABLE_READ) begin
			p1_v_nxt = 1'b1;
			p1_ram_nxt = 1'b1;
			p1_int_nxt = mc_mode && ({1'b0, tbl_r} < ROM_LIMIT);
			p1_word_nxt = rom_rd(tbl_r);
		end
	end

	assign word2 = p2_int_r ? p2_word_r : data_s2_r;

	always_comb begin
		instr_v_nxt = p2_v_r && !p2_ram_r;
		instr_nxt = instr_v_nxt ? word2 : instr_r;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p1_v_r <= 1'b0;
			p1_ram_r <= 1'b0;
			p1_int_r <= 1'b1;
			p1_word_r <= `WORD_RESET;
			p1_dma_r <= 8'h00;
			p2_v_r <= 1'b0;
			p2_ram_r <= 1'b0;
			p2_int_r <= 1'b1;
			p2_word_r <= `WORD_RESET;
			p2_dma_r <= 8'h00;
			instr_r <= `WORD_RESET;
			instr_v_r <= 1'b0;
		end else if (ce_i) begin
			p1_v_r <= p1_v_nxt;
			p1_ram_r <= p1_ram_nxt;
			p1_int_r <= p1_int_nxt;
			p1_word_r <= p1_word_nxt;
			p1_dma_r <= dma_r;
			p2_v_r <= p1_v_r;
			p2_ram_r <= p1_ram_r;
			p2_int_r <= p1_int_r;
			p2_word_r <= p1_word_r;
			p2_dma_r <= p1_dma_r;
			instr_r <= instr_nxt;
			instr_v_r <= instr_v_nxt;
		end
	end

	// Memory arrays carry no reset; writes past the fitted size are dropped
	always_ff @(posedge clk_i) begin
		if (ce_i && prog_we_i && ({1'b0, prog_addr_i} < ROM_LIMIT)) begin
			rom_mem[prog_addr_i] <= prog_data_i;
		end
		if (ce_i && p2_v_r && p2_ram_r && ({1'b0, p2_dma_r} < RAM_LIMIT)) begin
			ram_mem[p2_dma_r] <= word2;
		end
	end

	// Control register halves written by output to ports 0 and 1, on serial variants only
	always_comb begin
		sc_lo_nxt = sc_lo_r;
		sc_hi_nxt = sc_hi_r;
		if (state_r == ST_IO && op_r == OP_OUT && port_int(port_r)) begin
			if (port_r == `PORT_SYSCTL_HIGH) begin
				sc_hi_nxt = dout_r;
			end else begin
				sc_lo_nxt = dout_r;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sc_lo_r <= `SYSCTL_RESET;
			sc_hi_r <= `SYSCTL_RESET;
		end else if (ce_i) begin
			sc_lo_r <= sc_lo_nxt;
			sc_hi_r <= sc_hi_nxt;
		end
	end

	// Strobes: memory enable yields only to the data and write strobes
	assign data_enable_strobe_n_o = !(state_r == ST_IO && op_r == OP_IN);
	assign write_strobe_n_o = !((state_r == ST_IO && op_r == OP_OUT)
		|| (state_r == ST_TBL1 && op_r == OP_TABLE_WRITE));
	assign memory_enable_strobe_n_o = !data_enable_strobe_n_o
		|| !write_strobe_n_o;
	assign addr_o = (state_r == ST_IO) ? {9'h000, port_r}
		: ((state_r == ST_TBL1) ? tbl_r : pc_r);
	assign data_oe_o = !write_strobe_n_o;
	assign data_o = dout_r;
	assign cmd_ready_o = (state_r == ST_RUN);
	assign instr_o = instr_r;
	assign instr_valid_o = instr_v_r;
	assign next_fetch_pointer_o = pc_r;
	assign data_page_bit_o = dp_r;
	assign address_reg_select_o = arp_r;
	assign address_reg_zero_o = aux_val[0];
	assign address_reg_one_o = aux_val[1];
	assign system_control_o = {sc_hi_r, sc_lo_r};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	pc_advance_a: assert property (accept && cmd_op_i == OP_NEXT
		|=> pc_r == $past(pc_r) + `PC_STEP)
		else $error("pointer did not advance by one");
	call_push_a: assert property (accept && cmd_op_i == OP_CALL
		|=> stack_r[0] == $past(pc_r) + `PC_STEP
			&& stack_r[1] == $past(stack_r[0]))
		else $error("call did not push return address");
	io_port_addr_a: assert property (state_r == ST_IO
		|-> addr_o == {9'h000, port_r} && memory_enable_strobe_n_o)
		else $error("port address not on address lines");
	// Checked on the latched operand address, not on its own expression
	direct_page_a: assert property (accept && cmd_direct_i
		|=> dma_r == {$past(dp_r), $past(cmd_offset_i)})
		else $error("direct address not page plus offset");
	aux_count_a: assert property (accept && !cmd_direct_i
		&& cmd_aux_mod_i == AUX_INC && cmd_op_i != OP_LAR && !arp_r
		|=> aux_val[0][15:9] == $past(aux_val[0][15:9])
			&& aux_val[0][8:0] == $past(aux_val[0][8:0]) + 9'h001)
		else $error("address counter step wrong");
	arp_select_a: assert property (accept && !cmd_direct_i
		|=> dma_r == ($past(arp_r) ? $past(address_reg_one_o[7:0])
			: $past(address_reg_zero_o[7:0])))
		else $error("wrong address register active");
	strobe_excl_a: assert property (!memory_enable_strobe_n_o
		|-> data_enable_strobe_n_o && write_strobe_n_o)
		else $error("memory enable overlaps I/O strobe");
	run_men_a: assert property (state_r == ST_RUN
		|-> !memory_enable_strobe_n_o && addr_o == pc_r)
		else $error("fetch cycle lacks memory enable");
	io_len_a: assert property (accept && cmd_op_i == OP_IN
		|=> !cmd_ready_o ##1 (ce_i ? cmd_ready_o : !cmd_ready_o))
		else $error("port input not two cycles");
	// Two busy cycles after the accept, then run again
	tbl_len_a: assert property (accept && cmd_op_i == OP_TABLE_READ
		##1 ce_i [*2] |=> !$past(cmd_ready_o, 2) && !$past(cmd_ready_o)
			&& cmd_ready_o)
		else $error("table read not three cycles");
	// All three edges, both pipe stages and the output register, must be enabled for the word to arrive on time
	ext_fetch_a: assert property (ce_i && state_r == ST_RUN && ext_pc
		##1 ce_i [*2] |=> instr_valid_o && !$past(p2_int_r)
			&& $past(p1_v_r, 2) && !$past(p1_int_r, 2))
		else $error("external fetch not taken from bus");

	call_c: cover property (accept && cmd_op_i == OP_CALL);
	table_read_c: cover property (accept && cmd_op_i == OP_TABLE_READ ##3 cmd_ready_o);
	out_c: cover property (state_r == ST_IO && !write_strobe_n_o);
	ext_c: cover property (!mc_mode && instr_valid_o);

endmodule

/* tb/dsp_memory_organization_fetch_bench.sv */
`timescale 1ns/1ps
module dsp_memory_organization_fetch_bench;
	import fetch_pkg::*;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic ce_i = 1'h1;
	logic mode = 1'h1;
	logic cmd_valid_i = 1'h0;
	op_t cmd_op_i = OP_NEXT;
	logic [11:0] cmd_target_i = 12'h000;
	logic [15:0] cmd_data_i = 16'h0000;
	logic cmd_direct_i = 1'h1;
	logic [6:0] cmd_offset_i = 7'h05;
	logic cmd_aux_sel_i = 1'h0;
	aux_mod_t cmd_aux_mod_i = AUX_KEEP;
	logic prog_we_i = 1'h0;
	logic [11:0] prog_addr_i = 12'h000;
	logic [15:0] prog_data_i = 16'h0000;
	logic cmd_ready_o, data_oe_o, men_n, den_n, we_n, instr_valid_o;
	logic data_page_bit_o, address_reg_select_o;
	logic [15:0] data_i, data_o, instr_o, aux0, aux1;
	logic [11:0] addr_o, next_fetch_pointer_o;
	logic [31:0] system_control_o;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [11:0] q[$];

	fetch_unit dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.memory_mode_pin_i(mode), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_target_i(cmd_target_i),
		.cmd_data_i(cmd_data_i), .cmd_direct_i(cmd_direct_i),
		.cmd_offset_i(cmd_offset_i), .cmd_aux_sel_i(cmd_aux_sel_i),
		.cmd_aux_mod_i(cmd_aux_mod_i), .cmd_ready_o(cmd_ready_o),
		.prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i),
		.prog_data_i(prog_data_i), .data_i(data_i), .data_o(data_o),
		.data_oe_o(data_oe_o), .addr_o(addr_o),
		.memory_enable_strobe_n_o(men_n), .data_enable_strobe_n_o(den_n),
		.write_strobe_n_o(we_n), .instr_o(instr_o),
		.instr_valid_o(instr_valid_o),
		.next_fetch_pointer_o(next_fetch_pointer_o),
		.data_page_bit_o(data_page_bit_o),
		.address_reg_select_o(address_reg_select_o),
		.address_reg_zero_o(aux0), .address_reg_one_o(aux1),
		.system_control_o(system_control_o));

	prog_mem_model mem_u (.clk_i(clk_i), .addr_i(addr_o), .men_n_i(men_n),
		.den_n_i(den_n), .we_n_i(we_n), .wdata_i(data_o),
		.rdata_o(data_i));

	// Clock and a hang guard well beyond the planned run
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			end_of_test;
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Strobes packed as men, den, we, oe
	task bus(input logic [11:0] a, input logic [3:0] s);
		chk("addr_o", 32'(a), 32'(addr_o));
		chk("strobes", 32'(s), 32'({men_n, den_n, we_n, data_oe_o}));
	endtask

	// Offer a command at an edge; returns at the accepting edge
	task cmd(input op_t op, input logic [11:0] t, input logic [15:0] d);
		cmd_op_i <= op;
		cmd_target_i <= t;
		cmd_data_i <= d;
		cmd_valid_i <= 1'h1;
		@(posedge clk_i);
	endtask

	// Single command, then mid-cycle of the first cycle after it
	task one(input op_t op, input logic [11:0] t, input logic [15:0] d);
		cmd(op, t, d);
		cmd_valid_i <= 1'h0;
		#50;
	endtask

	task rdy(input logic r);
		@(posedge clk_i);
		#50;
		chk("cmd_ready_o", 32'(r), 32'(cmd_ready_o));
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		#50;
		bus(12'h000, 4'h6);
		chk("pointer", 32'h0, 32'(next_fetch_pointer_o));
		chk("aux", 32'h0, {aux1, aux0});
		chk("sysctl", 32'h0, system_control_o);
		@(posedge clk_i);
		rst_n_i <= 1'h1;
		prog_we_i <= 1'h1;
		prog_addr_i <= 12'h010;
		prog_data_i <= 16'h1234;
		@(posedge clk_i);
		prog_we_i <= 1'h0;
		// Internal store still shows the pointer with memory enable low
		one(OP_BRANCH, 12'h010, 16'h0000);
		bus(12'h010, 4'h6);
		repeat (3) @(posedge clk_i);
		#50;
		chk("instr_o", 32'h1234, 32'(instr_o));
		@(posedge clk_i);
		mode <= 1'h0;
		repeat (4) @(posedge clk_i);
		// Back-to-back fetches from outside at one word a cycle
		cmd_op_i <= OP_NEXT;
		cmd_valid_i <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			#50;
			q.push_back(addr_o);
			if (i >= 3) begin
				chk("instr_o", 32'(16'h5A00 ^ {4'h0, q[i-3]}),
					32'(instr_o));
				chk("instr_valid_o", 32'h1, 32'(instr_valid_o));
				chk("pointer step", 32'(q[i-1] + 12'h001), 32'(q[i]));
			end
		end
		@(posedge clk_i);
		// Five nested calls overflow the four-deep stack
		cmd(OP_BRANCH, 12'h100, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			cmd(OP_CALL, 12'(12'h200 + 12'h100 * i), 16'h0000);
		end
		for (int i = 0; i < 5; i++) begin
			one(OP_RET, 12'h000, 16'h0000);
			chk("ret", (i < 4) ? 32'(12'h501 - 12'h100 * i) : 32'h201,
				32'(next_fetch_pointer_o));
			@(posedge clk_i);
		end
		// Port in, table write, table read, port out round trip
		one(OP_IN, 12'h000, 16'h0003);
		bus(12'h003, 4'hA);
		chk("cmd_ready_o", 32'h0, 32'(cmd_ready_o));
		rdy(1'h1);
		repeat (3) @(posedge clk_i);
		one(OP_TABLE_WRITE, 12'h000, 16'h0ABC);
		bus(12'hABC, 4'hD);
		rdy(1'h0);
		chk("men_n", 32'h0, 32'(men_n));
		rdy(1'h1);
		@(posedge clk_i);
		cmd_offset_i <= 7'h09;
		one(OP_TABLE_READ, 12'h000, 16'h0ABC);
		bus(12'hABC, 4'h6);
		rdy(1'h0);
		rdy(1'h1);
		repeat (4) @(posedge clk_i);
		one(OP_OUT, 12'h000, 16'h0006);
		bus(12'h006, 4'hD);
		chk("data_o", 32'hD003, 32'(data_o));
		rdy(1'h1);
		@(posedge clk_i);
		// Register select, load, nine-bit wrap both ways, page bit
		one(OP_LARP, 12'h000, 16'h0001);
		chk("select", 32'h1, 32'(address_reg_select_o));
		@(posedge clk_i);
		cmd_aux_sel_i <= 1'h1;
		one(OP_LAR, 12'h000, 16'hFDFF);
		chk("aux1", 32'hFDFF, 32'(aux1));
		@(posedge clk_i);
		cmd_direct_i <= 1'h0;
		cmd_aux_mod_i <= AUX_INC;
		one(OP_NEXT, 12'h000, 16'h0000);
		chk("aux1 inc", 32'hFC00, {aux0, aux1});
		@(posedge clk_i);
		cmd_aux_mod_i <= AUX_DEC;
		one(OP_NEXT, 12'h000, 16'h0000);
		chk("aux1 dec", 32'hFDFF, 32'(aux1));
		@(posedge clk_i);
		cmd_aux_mod_i <= AUX_KEEP;
		one(OP_LDP, 12'h000, 16'h0001);
		chk("page", 32'h1, 32'(data_page_bit_o));
		// Enable low: an offered branch must not move the pointer
		@(posedge clk_i);
		ce_i <= 1'h0;
		cmd(OP_BRANCH, 12'h777, 16'h0000);
		repeat (2) @(posedge clk_i);
		#50;
		chk("frozen pointer", 32'h20A, 32'(next_fetch_pointer_o));
		@(posedge clk_i);
		ce_i <= 1'h1;
		one(OP_BRANCH, 12'h777, 16'h0000);
		chk("pointer", 32'h777, 32'(next_fetch_pointer_o));
		end_of_test;
	end
endmodule

/* tb/prog_mem_model.sv */
`timescale 1ns/1ps
module prog_mem_model (
	input wire logic clk_i,
	input wire logic [11:0] addr_i,
	input wire logic men_n_i,
	input wire logic den_n_i,
	input wire logic we_n_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [4096];
	logic [15:0] last_r;
	// Each word tells its own address apart, so a wrong fetch shows
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 16'h5A00 ^ 16'(i);
		end
		last_r = 16'h0000;
	end
	// Released bus shows a changing value, so stale data never passes
	always_comb begin
		if (!men_n_i) begin
			rdata_o = mem[addr_i];
		end else if (!den_n_i) begin
			rdata_o = {4'hD, addr_i};
		end else begin
			rdata_o = ~last_r;
		end
	end
	// Peripherals share the store; fine while ports stay below code
	always @(posedge clk_i) begin
		last_r <= rdata_o;
		if (!we_n_i) begin
			mem[addr_i] <= wdata_i;
		end
	end
endmodule
